// ==== logic/sync_pkg.sv ====
`default_nettype none
package sync_pkg;

  // word indices of the configuration port
  localparam logic [4:0] CTRL_IDX       = 5'h00;
  localparam logic [4:0] STATUS_IDX     = 5'h01;
  localparam logic [4:0] IRQ_IDX        = 5'h02;
  localparam logic [4:0] TRIG_DIS_IDX   = 5'h03;
  localparam logic [4:0] NUM_WRITES_IDX = 5'h04;
  localparam logic [4:0] ENTRY_BASE_IDX = 5'h05;

  // field positions
  localparam int RUN_BIT     = 0;
  localparam int IRQ_EN_BIT  = 1;
  localparam int DONE_BIT    = 1;
  localparam int TRIG_DIS_BIT = 0;

  // reset values
  localparam logic       RUN_RST        = 1'b0;
  localparam logic       IRQ_EN_RST     = 1'b0;
  localparam logic       TRIG_DIS_RST   = 1'b0;
  localparam logic [3:0] NUM_WRITES_RST = 4'h0;
  localparam logic [15:0] SIZE_RST      = 16'h0000;

  // packet type nibble carried by the first beat
  localparam logic [3:0] PKT_VIDEO = 4'h0;
  localparam logic [3:0] PKT_CTRL  = 4'hf;

  // symbols 0..3 carry width, 4..7 carry height, msb nibble first
  localparam int WIDTH_SYMS  = 4;
  localparam int HEIGHT_SYMS = 8;

endpackage : sync_pkg
`default_nettype wire

// ==== logic/stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(
  parameter int DW = 24
);
  logic [DW-1:0] data;
  logic          sop;
  logic          eop;
  logic          valid;
  logic          ready;

  modport src (output data, output sop, output eop, output valid, input ready);
  modport snk (input data, input sop, input eop, input valid, output ready);
endinterface : stream_if
`default_nettype wire

// ==== logic/beat_buffer.sv ====
`timescale 1ns/1ps
`default_nettype none
module beat_buffer #(
  parameter int DW    = 24,
  parameter int DEPTH = 2
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  stream_if.snk     in_s,
  stream_if.src     out_s
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2) begin : g_bad_depth
      $error("beat_buffer needs at least two entries");
    end
  endgenerate

  logic [DW+1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0]   count_ff;
  logic          push;
  logic          pop;

  // honest full and empty from the occupancy count
  assign in_s.ready  = (count_ff != (PW+1)'(DEPTH));
  assign out_s.valid = (count_ff != '0);
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;
  assign {out_s.sop, out_s.eop, out_s.data} = mem_ff[rd_ptr_ff];

  // storage has no reset, only the pointers and the count need one
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= {in_s.sop, in_s.eop, in_s.data};
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : beat_buffer
`default_nettype wire

// ==== logic/video_event_control_writer.sv ====
// How it works
// - stream passes through unchanged while every packet is inspected
// - a control packet whose width or height differs from the last triggers
// - width changes count only with the width-trigger build option
// - height changes count only with the height-trigger build option
// - optional build option triggers on every video data packet start
// - a trigger with a nonzero write count stalls the stream at once: input blocked, output withheld
// - while stalled, each stored word up to the word-4 count is written to its paired address
// - stall released only after the last write is accepted
// - completion flag raised once all writes of one trigger are done
// - a configuration write port loads target addresses and data words
// - trigger-disable word blocks any new write sequence while set
// - re-arm option disables triggering after each trigger until software re-enables
// - entry count is a build parameter 1 to 10, default 3
// - bits per color plane is a build parameter 4 to 20, default 8
// - color planes per pixel is a build parameter 1 to 4, default 3
// - build option selects planes side by side or in successive beats
// - control word holds run in bit 0 and interrupt enable in bit 1
// - interrupt word bit 1 shows completion; writing one clears it
// - word 3 disables triggering when 1; re-arm option sets it on trigger
// - word 4 gives entries per trigger; pairs start at words 5 and 6
`timescale 1ns/1ps
`default_nettype none
module video_event_control_writer #(
  parameter int BPS       = 8,
  parameter int PLANES    = 3,
  parameter bit PARALLEL  = 1'b1,
  parameter bit TRIG_W    = 1'b1,
  parameter bit TRIG_H    = 1'b1,
  parameter bit TRIG_SOP  = 1'b0,
  parameter bit REARM     = 1'b0,
  parameter int N_ENTRIES = 3,
  parameter int AW        = 32,
  parameter int MW        = 32,
  parameter int SPB       = PARALLEL ? PLANES : 1,
  parameter int DW        = BPS * SPB
) (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  // incoming video stream
  input  wire logic [DW-1:0] in_data_i,
  input  wire logic          in_sop_i,
  input  wire logic          in_eop_i,
  input  wire logic          in_valid_i,
  output logic               in_ready_o,
  // outgoing video stream
  output logic [DW-1:0]      out_data_o,
  output logic               out_sop_o,
  output logic               out_eop_o,
  output logic               out_valid_o,
  input  wire logic          out_ready_i,
  // configuration write port
  input  wire logic          cfg_wr_i,
  input  wire logic [4:0]    cfg_idx_i,
  input  wire logic [31:0]   cfg_data_i,
  // state shown to software
  output logic               run_o,
  output logic               irq_en_o,
  output logic               busy_o,
  output logic               done_flag_o,
  output logic               trig_disabled_o,
  output logic [3:0]         num_writes_o,
  output logic               irq_o,
  // memory-mapped write master
  output logic               mm_write_o,
  output logic [AW-1:0]      mm_address_o,
  output logic [MW-1:0]      mm_writedata_o,
  input  wire logic          mm_waitrequest_i
);

  // build options outside what the logic can serve are refused
  generate
    if (BPS < 4 || BPS > 20 || PLANES < 1 || PLANES > 4 ||
        N_ENTRIES < 1 || N_ENTRIES > 10 || AW > 32 || MW > 32) begin : g_bad_cfg
      $error("video_event_control_writer: unsupported parameter values");
    end
  endgenerate

  localparam int EW = $clog2(N_ENTRIES + 1);

  typedef enum logic [0:0] {ST_PASS, ST_WRITE} wr_state_t;

  // configuration state
  logic               run_ff;
  logic               irq_en_ff;
  logic               trig_dis_ff;
  logic [3:0]         num_writes_ff;
  logic               done_ff;
  logic [AW-1:0]      addr_mem [N_ENTRIES];
  logic [MW-1:0]      word_mem [N_ENTRIES];

  // stream inspection state
  logic               in_pkt_ff;
  logic               in_ctrl_ff;
  logic [3:0]         beat_cnt_ff;
  logic [15:0]        cap_w_ff;
  logic [15:0]        cap_h_ff;
  logic [15:0]        prev_w_ff;
  logic [15:0]        prev_h_ff;
  logic [15:0]        nxt_cap_w;
  logic [15:0]        nxt_cap_h;

  // write sequencing state
  wr_state_t          state_ff;
  logic               stall_ff;
  logic [EW-1:0]      ent_ff;
  logic [EW-1:0]      last_ent;
  logic [3:0]         req_writes;

  logic               in_fire;
  logic               sop_trig;
  logic               ctrl_trig;
  logic               trigger;
  logic               wr_accept;
  logic               seq_done;
  logic               cfg_entry;
  logic [4:0]         cfg_off;
  logic [3:0]         cfg_ent;
  logic               done_clr;

  stream_if #(.DW(DW)) buf_in_s ();
  stream_if #(.DW(DW)) buf_out_s ();

  beat_buffer #(
    .DW    (DW),
    .DEPTH (2)
  ) u_buf (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .in_s    (buf_in_s),
    .out_s   (buf_out_s)
  );

  // a stopped core finishes the packet in flight but takes no new one
  assign in_ready_o = buf_in_s.ready & ~stall_ff & (run_ff | in_pkt_ff);
  assign in_fire    = in_valid_i & in_ready_o;

  // beats go into the buffer untouched
  assign buf_in_s.data  = in_data_i;
  assign buf_in_s.sop   = in_sop_i;
  assign buf_in_s.eop   = in_eop_i;
  assign buf_in_s.valid = in_valid_i & ~stall_ff & (run_ff | in_pkt_ff);

  // the trigger beat already sits in the buffer and is held there too
  assign out_valid_o     = buf_out_s.valid & ~stall_ff;
  assign buf_out_s.ready = out_ready_i & ~stall_ff;
  assign out_data_o      = buf_out_s.data;
  assign out_sop_o       = buf_out_s.sop;
  assign out_eop_o       = buf_out_s.eop;

  // configuration write decode
  assign cfg_off   = cfg_idx_i - sync_pkg::ENTRY_BASE_IDX;
  assign cfg_ent   = cfg_off[4:1];
  assign cfg_entry = cfg_wr_i && (cfg_idx_i >= sync_pkg::ENTRY_BASE_IDX) &&
                     (cfg_ent < 4'(N_ENTRIES));
  assign done_clr  = cfg_wr_i && (cfg_idx_i == sync_pkg::IRQ_IDX) &&
                     cfg_data_i[sync_pkg::DONE_BIT];

  // control word
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      run_ff    <= sync_pkg::RUN_RST;
      irq_en_ff <= sync_pkg::IRQ_EN_RST;
    end else if (cfg_wr_i && cfg_idx_i == sync_pkg::CTRL_IDX) begin
      run_ff    <= cfg_data_i[sync_pkg::RUN_BIT];
      irq_en_ff <= cfg_data_i[sync_pkg::IRQ_EN_BIT];
    end
  end

  // trigger disable: the hardware set on trigger beats a software clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      trig_dis_ff <= sync_pkg::TRIG_DIS_RST;
    end else if (REARM && trigger) begin
      trig_dis_ff <= 1'b1;
    end else if (cfg_wr_i && cfg_idx_i == sync_pkg::TRIG_DIS_IDX) begin
      trig_dis_ff <= cfg_data_i[sync_pkg::TRIG_DIS_BIT];
    end
  end

  // entries per trigger; values above the table size are clamped on write
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      num_writes_ff <= sync_pkg::NUM_WRITES_RST;
    end else if (cfg_wr_i && cfg_idx_i == sync_pkg::NUM_WRITES_IDX) begin
      num_writes_ff <= (cfg_data_i > 32'(N_ENTRIES)) ? 4'(N_ENTRIES) : cfg_data_i[3:0];
    end
  end

  // address and word table, odd offset holds the word
  always_ff @(posedge clock_i) begin
    if (cfg_entry && !cfg_off[0]) begin
      addr_mem[cfg_ent[EW-1:0]] <= cfg_data_i[AW-1:0];
    end
    if (cfg_entry && cfg_off[0]) begin
      word_mem[cfg_ent[EW-1:0]] <= cfg_data_i[MW-1:0];
    end
  end

  // packet framing: type nibble sits in the low bits of the first beat
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      in_pkt_ff   <= 1'b0;
      in_ctrl_ff  <= 1'b0;
      beat_cnt_ff <= 4'h0;
    end else if (in_fire) begin
      in_pkt_ff <= ~in_eop_i;
      if (in_sop_i) begin
        in_ctrl_ff  <= (in_data_i[3:0] == sync_pkg::PKT_CTRL) & ~in_eop_i;
        beat_cnt_ff <= 4'h0;
      end else begin
        in_ctrl_ff  <= in_ctrl_ff & ~in_eop_i;
        beat_cnt_ff <= (beat_cnt_ff == 4'hf) ? beat_cnt_ff : beat_cnt_ff + 4'h1;
      end
    end
  end

  // gather width and height nibbles from every symbol of the beat
  always_comb begin
    int s;
    s = 0;
    nxt_cap_w = cap_w_ff;
    nxt_cap_h = cap_h_ff;
    for (int j = 0; j < SPB; j++) begin
      s = int'(beat_cnt_ff) * SPB + j;
      if (s < sync_pkg::WIDTH_SYMS) begin
        nxt_cap_w[(3 - s) * 4 +: 4] = in_data_i[j * BPS +: 4];
      end else if (s < sync_pkg::HEIGHT_SYMS) begin
        nxt_cap_h[(7 - s) * 4 +: 4] = in_data_i[j * BPS +: 4];
      end
    end
  end

  // capture holds the packet in flight, prev the last completed one
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cap_w_ff  <= sync_pkg::SIZE_RST;
      cap_h_ff  <= sync_pkg::SIZE_RST;
      prev_w_ff <= sync_pkg::SIZE_RST;
      prev_h_ff <= sync_pkg::SIZE_RST;
    end else if (in_fire && in_ctrl_ff && !in_sop_i) begin
      cap_w_ff <= nxt_cap_w;
      cap_h_ff <= nxt_cap_h;
      if (in_eop_i) begin
        prev_w_ff <= nxt_cap_w;
        prev_h_ff <= nxt_cap_h;
      end
    end
  end

  // trigger sources; a short control packet still compares what it carried
  assign sop_trig  = TRIG_SOP && in_fire && in_sop_i &&
                     (in_data_i[3:0] == sync_pkg::PKT_VIDEO);
  assign ctrl_trig = in_fire && in_ctrl_ff && !in_sop_i && in_eop_i &&
                     ((TRIG_W && nxt_cap_w != prev_w_ff) ||
                      (TRIG_H && nxt_cap_h != prev_h_ff));
  assign trigger   = (sop_trig | ctrl_trig) && !trig_dis_ff &&
                     (state_ff == ST_PASS);

  // sequence bounds
  assign req_writes = (num_writes_ff > 4'(N_ENTRIES)) ? 4'(N_ENTRIES) : num_writes_ff;
  assign last_ent   = EW'(req_writes - 4'h1);
  assign wr_accept  = (state_ff == ST_WRITE) && !mm_waitrequest_i;
  assign seq_done   = (trigger && req_writes == 4'h0) || (wr_accept && ent_ff == last_ent);

  // write sequencer, one write outstanding at a time
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_PASS;
      stall_ff <= 1'b0;
      ent_ff   <= '0;
    end else begin
      case (state_ff)
        ST_PASS: begin
          if (trigger) begin
            stall_ff <= (req_writes != 4'h0);
            ent_ff   <= '0;
            state_ff <= (req_writes != 4'h0) ? ST_WRITE : ST_PASS;
          end
        end
        ST_WRITE: begin
          if (wr_accept) begin
            if (ent_ff == last_ent) begin
              stall_ff <= 1'b0;
              state_ff <= ST_PASS;
            end else begin
              ent_ff <= ent_ff + 1'b1;
            end
          end
        end
        default: begin
          state_ff <= ST_PASS;
          stall_ff <= 1'b0;
        end
      endcase
    end
  end

  // master request stands until the slave lifts waitrequest
  assign mm_write_o     = (state_ff == ST_WRITE);
  assign mm_address_o   = addr_mem[ent_ff];
  assign mm_writedata_o = word_mem[ent_ff];

  // completion flag: set wins over a clear in the same cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
    end else if (seq_done) begin
      done_ff <= 1'b1;
    end else if (done_clr) begin
      done_ff <= 1'b0;
    end
  end

  // software-visible state
  assign irq_o           = done_ff & irq_en_ff;
  assign run_o           = run_ff;
  assign irq_en_o        = irq_en_ff;
  assign busy_o          = in_pkt_ff | stall_ff;
  assign done_flag_o     = done_ff;
  assign trig_disabled_o = trig_dis_ff;
  assign num_writes_o    = num_writes_ff;

endmodule : video_event_control_writer
`default_nettype wire

// ==== testbench/vecw_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module vecw_props #(
  parameter int N_ENTRIES = 3,
  parameter bit REARM     = 1'b0,
  parameter int AW        = 32,
  parameter int MW        = 32
) (
  input wire logic          clock_i,
  input wire logic          rst_i,
  input wire logic          in_valid_i,
  input wire logic          in_ready_o,
  input wire logic          out_valid_o,
  input wire logic          cfg_wr_i,
  input wire logic [4:0]    cfg_idx_i,
  input wire logic [31:0]   cfg_data_i,
  input wire logic          run_o,
  input wire logic          irq_en_o,
  input wire logic          done_flag_o,
  input wire logic          trig_disabled_o,
  input wire logic [3:0]    num_writes_o,
  input wire logic          irq_o,
  input wire logic          mm_write_o,
  input wire logic [AW-1:0] mm_address_o,
  input wire logic [MW-1:0] mm_writedata_o,
  input wire logic          mm_waitrequest_i
);
  // count a software write of word 4 saturates at the table size
  logic [3:0] clamp;
  logic [3:0] taken_ff;
  assign clamp = (cfg_data_i > N_ENTRIES) ? 4'(N_ENTRIES) : cfg_data_i[3:0];

  // accepted writes of the running sequence, cleared between sequences
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) taken_ff <= 4'h0;
    else if (!mm_write_o) taken_ff <= 4'h0;
    else if (!mm_waitrequest_i) taken_ff <= taken_ff + 4'h1;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  chk_stall_holds: assert property (mm_write_o |-> !out_valid_o && !in_ready_o)
    else $error("stream moved during writes");
  chk_write_steady: assert property (mm_write_o && mm_waitrequest_i |=>
    mm_write_o && $stable(mm_address_o) && $stable(mm_writedata_o))
    else $error("write changed before acceptance");
  chk_irq_level: assert property (irq_o == (done_flag_o && irq_en_o))
    else $error("irq level wrong");
  chk_start_armed: assert property ($rose(mm_write_o) |-> !$past(trig_disabled_o))
    else $error("writes started while disabled");
  chk_rearm_sets: assert property ($rose(mm_write_o) |-> trig_disabled_o || !REARM)
    else $error("trigger not disarmed");
  chk_ctrl_fields: assert property (cfg_wr_i && cfg_idx_i == sync_pkg::CTRL_IDX |=>
    {30'h0, irq_en_o, run_o} == ($past(cfg_data_i) & 32'h3))
    else $error("control bits wrong");
  chk_done_clears: assert property (cfg_wr_i && cfg_idx_i == sync_pkg::IRQ_IDX
    && cfg_data_i[sync_pkg::DONE_BIT] && !mm_write_o && !in_valid_i |=> !done_flag_o)
    else $error("done not cleared");
  chk_done_follows: assert property ($rose(done_flag_o) && num_writes_o != 4'h0 |->
    $past(mm_write_o) && !$past(mm_waitrequest_i))
    else $error("done without last write");
  chk_release_last: assert property ($fell(mm_write_o) |->
    done_flag_o && !$past(mm_waitrequest_i))
    else $error("stall released early");
  chk_write_count: assert property ($fell(mm_write_o) |-> taken_ff == num_writes_o)
    else $error("write count wrong");
  chk_num_clamp: assert property (cfg_wr_i && cfg_idx_i == sync_pkg::NUM_WRITES_IDX |=>
    num_writes_o == $past(clamp))
    else $error("write count register wrong");
endmodule : vecw_props

bind video_event_control_writer vecw_props #(
  .N_ENTRIES(N_ENTRIES), .REARM(REARM), .AW(AW), .MW(MW)
) chk_u (
  .clock_i(clock_i), .rst_i(rst_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
  .out_valid_o(out_valid_o), .cfg_wr_i(cfg_wr_i), .cfg_idx_i(cfg_idx_i),
  .cfg_data_i(cfg_data_i), .run_o(run_o), .irq_en_o(irq_en_o), .done_flag_o(done_flag_o),
  .trig_disabled_o(trig_disabled_o), .num_writes_o(num_writes_o), .irq_o(irq_o),
  .mm_write_o(mm_write_o), .mm_address_o(mm_address_o), .mm_writedata_o(mm_writedata_o),
  .mm_waitrequest_i(mm_waitrequest_i)
);
`default_nettype wire

// ==== testbench/stream_sink_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module stream_sink_model #(
  parameter int DW = 24
) (
  input  wire logic          clock_i,
  input  wire logic          slow_i,
  input  wire logic          hold_i,
  input  wire logic [DW-1:0] data_i,
  input  wire logic          sop_i,
  input  wire logic          eop_i,
  input  wire logic          valid_i,
  output var logic           ready_o,
  input  wire logic          write_i,
  input  wire logic [31:0]   address_i,
  input  wire logic [31:0]   writedata_i,
  output var logic           waitrequest_o
);
  logic [DW+1:0] beat_q[$];
  logic [63:0]   wr_q[$];
  int unsigned   ph = 0;

  initial begin
    ready_o = 1'b1;
    waitrequest_o = 1'b0;
  end

  // sample at the edge, then move like a downstream core; slow mode stalls both sides
  always @(posedge clock_i) begin
    if (write_i && !waitrequest_o) wr_q.push_back({address_i, writedata_i});
    if (valid_i && ready_o) beat_q.push_back({sop_i, eop_i, data_i});
    #1;
    ph = ph + 1;
    waitrequest_o = slow_i && (ph % 3 != 0);
    ready_o = !hold_i && !(slow_i && ph[0]);
  end
endmodule : stream_sink_model
`default_nettype wire

// ==== testbench/test_video_event_control_writer.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_video_event_control_writer;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [23:0] in_data_i = 24'h0;
  logic        in_sop_i = 1'b0;
  logic        in_eop_i = 1'b0;
  logic        in_valid_i = 1'b0;
  logic        cfg_wr_i = 1'b0;
  logic [4:0]  cfg_idx_i = 5'h0;
  logic [31:0] cfg_data_i = 32'h0;
  logic        slow = 1'b0;
  logic        hold = 1'b0;
  logic        out_ready_i, mm_waitrequest_i, in_ready_o, out_sop_o, out_eop_o, out_valid_o;
  logic        run_o, irq_en_o, busy_o, done_flag_o, trig_disabled_o, irq_o, mm_write_o;
  logic [23:0] out_data_o;
  logic [3:0]  num_writes_o;
  logic [31:0] mm_address_o, mm_writedata_o;
  logic [25:0] sent_q[$];
  int          bad_count = 0;
  int          checked = 0;

  // re-arm build option on, so every trigger disarms itself
  video_event_control_writer #(.REARM(1'b1)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .in_data_i(in_data_i), .in_sop_i(in_sop_i),
    .in_eop_i(in_eop_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .out_data_o(out_data_o), .out_sop_o(out_sop_o), .out_eop_o(out_eop_o),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .cfg_wr_i(cfg_wr_i),
    .cfg_idx_i(cfg_idx_i), .cfg_data_i(cfg_data_i), .run_o(run_o), .irq_en_o(irq_en_o),
    .busy_o(busy_o), .done_flag_o(done_flag_o), .trig_disabled_o(trig_disabled_o),
    .num_writes_o(num_writes_o), .irq_o(irq_o), .mm_write_o(mm_write_o),
    .mm_address_o(mm_address_o), .mm_writedata_o(mm_writedata_o),
    .mm_waitrequest_i(mm_waitrequest_i)
  );
  stream_sink_model sink_u (
    .clock_i(clock_i), .slow_i(slow), .hold_i(hold), .data_i(out_data_o), .sop_i(out_sop_o),
    .eop_i(out_eop_o), .valid_i(out_valid_o), .ready_o(out_ready_i), .write_i(mm_write_o),
    .address_i(mm_address_o), .writedata_i(mm_writedata_o), .waitrequest_o(mm_waitrequest_i)
  );

  // 100 ns period
  always #50 clock_i = ~clock_i;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic expire(input int n);
    if (n >= 200) begin
      bad_count++;
      report_and_stop();
    end
  endtask : expire

  // strobe gets a quiet cycle after it so two writes never collide
  task automatic cfg(input logic [4:0] idx, input logic [31:0] d);
    cfg_wr_i = 1'b1;
    cfg_idx_i = idx;
    cfg_data_i = d;
    @(posedge clock_i);
    #1;
    cfg_wr_i = 1'b0;
    @(posedge clock_i);
    #1;
  endtask : cfg

  task automatic put_beat(input logic [23:0] d, input logic s, input logic e);
    logic r;
    in_valid_i = 1'b1;
    in_data_i = d;
    in_sop_i = s;
    in_eop_i = e;
    for (int n = 0; n <= 200; n++) begin
      expire(n);
      @(negedge clock_i);
      r = in_ready_o;
      @(posedge clock_i);
      if (r) break;
    end
    sent_q.push_back({s, e, d});
    #1;
  endtask : put_beat

  // control symbols: width then height, msb nibble first, low plane first
  task automatic send_pkt(input logic [3:0] ty, input logic [15:0] w, input logic [15:0] h);
    logic [23:0] d;
    logic [63:0] syms;
    syms = {w, h, 32'h0};
    for (int b = 0; b < 4; b++) begin
      d = (b == 0) ? {20'h0, ty} : 24'h5a5a00 + 24'(b);
      if (b > 0 && ty == sync_pkg::PKT_CTRL) begin
        d = 24'h0;
        for (int j = 0; j < 3; j++) d[8*j +: 4] = syms[63-4*(3*b-3+j) -: 4];
      end
      put_beat(d, b == 0, b == 3);
    end
    in_valid_i = 1'b0;
    in_data_i = ~d;
  endtask : send_pkt

  task automatic drain;
    for (int n = 0; sink_u.beat_q.size() < sent_q.size(); n++) begin
      expire(n);
      @(posedge clock_i);
      #1;
    end
    while (sent_q.size() > 0) check("beat", sink_u.beat_q.pop_front(), sent_q.pop_front());
  endtask : drain

  // a trigger writes entries 0 and 1 only, then flags completion
  task automatic expect_trigger(input logic [15:0] w, input logic [15:0] h);
    // start from a cleared flag so each call proves a fresh completion
    cfg(sync_pkg::IRQ_IDX, 32'h2);
    send_pkt(sync_pkg::PKT_CTRL, w, h);
    drain();
    for (int k = 0; k < 2; k++)
      check("write", sink_u.wr_q.pop_front(), {32'(256 * (k + 1)), 32'hc0de0000 + k});
    check("extra writes", sink_u.wr_q.size(), 0);
    check("done", {done_flag_o, trig_disabled_o}, 2'h3);
  endtask : expect_trigger

  task automatic t_setup;
    check("reset", {run_o, irq_en_o, done_flag_o, trig_disabled_o, num_writes_o, irq_o}, 0);
    cfg(sync_pkg::CTRL_IDX, 32'h3);
    cfg(sync_pkg::NUM_WRITES_IDX, 32'h9);
    check("clamp", num_writes_o, 4'h3);
    cfg(sync_pkg::NUM_WRITES_IDX, 32'h2);
    for (int k = 0; k < 3; k++) begin
      cfg(5'(sync_pkg::ENTRY_BASE_IDX + 2 * k), 32'(256 * (k + 1)));
      cfg(5'(sync_pkg::ENTRY_BASE_IDX + 2 * k + 1), 32'hc0de0000 + k);
    end
    check("ctrl", {run_o, irq_en_o, num_writes_o}, 6'h32);
  endtask : t_setup

  task automatic t_irq;
    cfg(sync_pkg::CTRL_IDX, 32'h1);
    check("masked", {done_flag_o, irq_o}, 2'h2);
    cfg(sync_pkg::CTRL_IDX, 32'h3);
    cfg(sync_pkg::IRQ_IDX, 32'h1);
    check("kept", irq_o, 1'b1);
    cfg(sync_pkg::IRQ_IDX, 32'h2);
    check("cleared", {done_flag_o, irq_o}, 2'h0);
  endtask : t_irq

  task automatic t_disarmed;
    send_pkt(sync_pkg::PKT_CTRL, 16'd640, 16'd240);
    drain();
    check("disabled", sink_u.wr_q.size(), 0);
    cfg(sync_pkg::TRIG_DIS_IDX, 32'h0);
    send_pkt(sync_pkg::PKT_CTRL, 16'd640, 16'd240);
    send_pkt(sync_pkg::PKT_VIDEO, 16'h0, 16'h0);
    drain();
    check("no change", sink_u.wr_q.size(), 0);
    expect_trigger(16'd640, 16'd480);
    cfg(sync_pkg::TRIG_DIS_IDX, 32'h0);
    expect_trigger(16'd800, 16'd480);
    cfg(sync_pkg::TRIG_DIS_IDX, 32'h0);
    // empty write list: trigger completes at once, no stall, no bus write
    cfg(sync_pkg::NUM_WRITES_IDX, 32'h0);
    cfg(sync_pkg::IRQ_IDX, 32'h2);
    send_pkt(sync_pkg::PKT_CTRL, 16'd1024, 16'd480);
    drain();
    check("empty list writes", sink_u.wr_q.size(), 0);
    check("empty list done", {done_flag_o, trig_disabled_o}, 2'h3);
  endtask : t_disarmed

  // receiver stalls: the two-entry buffer fills and pushes back, nothing lost
  task automatic t_buffer;
    hold = 1'b1;
    fork
      send_pkt(sync_pkg::PKT_VIDEO, 16'h0, 16'h0);
      begin
        repeat (6) @(posedge clock_i);
        #1;
        check("full", {in_ready_o, out_valid_o}, 2'h1);
        check("in packet", busy_o, 1'b1);
        hold = 1'b0;
      end
    join
    drain();
    cfg(sync_pkg::CTRL_IDX, 32'h2);
    check("stopped", in_ready_o, 1'b0);
    check("idle", busy_o, 1'b0);
    cfg(sync_pkg::CTRL_IDX, 32'h3);
    check("started", in_ready_o, 1'b1);
  endtask : t_buffer

  initial begin
    repeat (4) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    t_setup();
    slow = 1'b1;
    expect_trigger(16'd320, 16'd240);
    check("irq", irq_o, 1'b1);
    slow = 1'b0;
    t_irq();
    t_disarmed();
    t_buffer();
    report_and_stop();
  end
endmodule : test_video_event_control_writer
`default_nettype wire
